// File: hdl/twssp_dev.sv
/*
  Device end: slave-only two-wire port with address selection and pointer.
  Assumes link_clk oversamples the bus well above the bus clock rate and
  that rd_data is supplied in the link_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "twssp_params.svh"
module twssp_dev
  import twssp_pkg::*;
#(
  parameter int VARIANT     = `TWSSP_VAR_PIN,
  parameter bit TRIPLE_B    = 1'b0,
  parameter int TIMEOUT_CYC = `TWSSP_TIMEOUT_CYC
) (
  input  wire logic        link_clk,           // Sampling clock of the link.
  input  wire logic        rst,                // Synchronous reset, high.
  twssp_if.device          bus,                // Two-wire bus.
  input  wire logic [1:0]  addr_select_hi_pin, // Bit1 float, bit0 level.
  input  wire logic [1:0]  addr_select_lo_pin, // Bit1 float, bit0 level.
  input  wire logic [3:0]  sense_rise,         // Sense pin pulled near supply.
  output logic      [3:0]  probe_drive_q,      // Sense pin fed probe current.
  input  wire logic [15:0] rd_data,            // Pointed register contents.
  output logic      [7:0]  ptr_q,              // Register pointer.
  output logic      [7:0]  wr_data_q,          // Written data byte.
  output logic             wr_stb_q,           // Data byte written, pulse.
  output logic             sw_reset_q,         // Software reset, pulse.
  output logic             hs_mode_q,          // High-speed mode active.
  output logic      [6:0]  own_addr_q          // Selected slave address.
);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int PW = $clog2(`TWSSP_PROBE_CYC + 1);

  twssp_dstate_t st_q;
  logic [1:0]    scl_sync_q;
  logic [1:0]    sda_sync_q;
  logic          scl_prev_q;
  logic          sda_prev_q;
  logic [3:0]    pin_m_q;
  logic [3:0]    pin_s_q;
  logic [3:0]    sense_m_q;
  logic [3:0]    sense_s_q;
  logic [3:0]    bit_q;
  logic          ack_q;
  logic          first_q;
  logic          gc_q;
  logic          lsb_q;
  logic          sda_oe_q;
  logic [7:0]    rx_q;
  logic [7:0]    tx_q;
  logic [7:0]    rd_byte;
  logic [2:0]    pstep_q;
  logic [2:0]    pstep_d;
  logic [PW-1:0] ptim_q;
  logic [1:0]    dual_bits_q;
  logic [TW-1:0] tmo_q;
  logic          s_scl;
  logic          s_sda;
  logic          start;
  logic          stop;
  logic          scl_rise;
  logic          scl_fall;
  logic          tmo_hit;
  logic          byte_in;

  // Open-drain data only; the clock line is never driven.
  assign bus.d_scl_o  = 1'b0;
  assign bus.d_scl_oe = 1'b0; // RULE1
  assign bus.d_sda_o  = 1'b0;
  assign bus.d_sda_oe = sda_oe_q;

  // Two-stage synchronisers for bus lines, straps and probe comparators.
  always_ff @(posedge link_clk) begin
    scl_sync_q <= {scl_sync_q[0], bus.scl}; // RULE3
    sda_sync_q <= {sda_sync_q[0], bus.sda};
    scl_prev_q <= scl_sync_q[1];
    sda_prev_q <= sda_sync_q[1];
    pin_m_q    <= {addr_select_hi_pin, addr_select_lo_pin};
    pin_s_q    <= pin_m_q;
    sense_m_q  <= sense_rise;
    sense_s_q  <= sense_m_q;
  end

  // Bus conditions seen on the synchronised lines.
  assign s_scl    = scl_sync_q[1];
  assign s_sda    = sda_sync_q[1];
  assign start    = s_scl && scl_prev_q && sda_prev_q && !s_sda; // RULE16
  assign stop     = s_scl && scl_prev_q && !sda_prev_q && s_sda; // RULE17
  assign scl_rise = s_scl && !scl_prev_q;
  assign scl_fall = !s_scl && scl_prev_q;
  assign tmo_hit  = (tmo_q == TW'(TIMEOUT_CYC - 1));
  assign byte_in  = scl_fall && (bit_q == 4'h8) && !ack_q;
  assign rd_byte  = lsb_q ? rd_data[7:0] : rd_data[15:8]; // RULE13

  // Next probe step: skip the second pin when the first did not rise.
  always_comb begin
    if (!pstep_q[0] && !sense_s_q[pstep_q[1:0]]) begin
      pstep_d = pstep_q + 3'h2; // RULE8
    end else begin
      pstep_d = pstep_q + 3'h1;
    end
  end

  // Polarity probe after reset and software reset, two pins per channel.
  always_ff @(posedge link_clk) begin
    if (rst || sw_reset_q) begin
      pstep_q       <= 3'h0;
      ptim_q        <= '0;
      dual_bits_q   <= 2'h0;
      probe_drive_q <= 4'h1; // RULE7
    end else if (!pstep_q[2]) begin
      if (ptim_q == PW'(`TWSSP_PROBE_CYC - 1)) begin
        ptim_q  <= '0;
        pstep_q <= pstep_d;
        // Channel one feeds bit 1, channel two feeds bit 0.
        if (pstep_q[0]) begin
          dual_bits_q[~pstep_q[1]] <= !sense_s_q[pstep_q[1:0]]; // RULE7
        end else if (!sense_s_q[pstep_q[1:0]]) begin
          dual_bits_q[~pstep_q[1]] <= 1'b0; // RULE8
        end
        probe_drive_q <= pstep_d[2] ? 4'h0 : (4'h1 << pstep_d[1:0]);
      end else begin
        ptim_q <= ptim_q + 1'b1;
      end
    end
  end

  // Own address by build variant.
  always_ff @(posedge link_clk) begin
    if (VARIANT == `TWSSP_VAR_DUAL) begin
      own_addr_q <= {`TWSSP_ADDR_BASE, dual_bits_q}; // RULE6
    end else if (VARIANT == `TWSSP_VAR_TRIPLE) begin
      own_addr_q <= TRIPLE_B ? `TWSSP_ADDR_TRI_B : `TWSSP_ADDR_TRI_A; // RULE9
    end else begin
      casez (pin_s_q) // RULE5
        4'b1?_00: own_addr_q <= `TWSSP_ADDR_F0;
        4'b1?_01: own_addr_q <= `TWSSP_ADDR_F1;
        4'b00_1?: own_addr_q <= `TWSSP_ADDR_0F;
        4'b01_1?: own_addr_q <= `TWSSP_ADDR_1F;
        4'b1?_1?: own_addr_q <= `TWSSP_ADDR_FF;
        default:  own_addr_q <= {`TWSSP_ADDR_BASE, pin_s_q[2], pin_s_q[0]};
      endcase
    end
  end

  // Stuck-low watchdog inside a transfer; any line edge restarts it.
  always_ff @(posedge link_clk) begin
    if (rst || st_q == D_IDLE || (s_scl && s_sda) ||
        s_scl != scl_prev_q || s_sda != sda_prev_q) begin
      tmo_q <= '0;
    end else if (!tmo_hit) begin
      tmo_q <= tmo_q + 1'b1; // RULE23
    end
  end

  // Protocol engine: address match, pointer, write data, read shifting.
  always_ff @(posedge link_clk) begin
    wr_stb_q   <= 1'b0;
    sw_reset_q <= 1'b0;
    if (rst) begin
      st_q      <= D_IDLE;
      bit_q     <= 4'h0;
      ack_q     <= 1'b0;
      first_q   <= 1'b0;
      gc_q      <= 1'b0;
      lsb_q     <= 1'b0;
      sda_oe_q  <= 1'b0;
      rx_q      <= 8'h00;
      tx_q      <= 8'h00;
      ptr_q     <= `TWSSP_PTR_RESET;
      wr_data_q <= 8'h00;
      hs_mode_q <= 1'b0;
    end else if (stop || tmo_hit) begin
      st_q     <= D_IDLE; // RULE20
      ack_q    <= 1'b0;
      sda_oe_q <= 1'b0; // RULE23
      if (stop) begin
        hs_mode_q <= 1'b0; // RULE22
      end
    end else if (start) begin
      st_q     <= D_ADDR;
      bit_q    <= 4'h0;
      ack_q    <= 1'b0;
      gc_q     <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      case (st_q)
        D_ADDR, D_WRITE: begin
          if (scl_rise && !ack_q && bit_q != 4'h8) begin
            rx_q  <= {rx_q[6:0], s_sda}; // RULE2
            bit_q <= bit_q + 4'h1;
          end else if (byte_in && st_q == D_ADDR) begin
            lsb_q   <= 1'b0;
            first_q <= 1'b1;
            if (rx_q[7:1] == own_addr_q) begin
              ack_q    <= 1'b1; // RULE19
              sda_oe_q <= 1'b1;
              st_q     <= rx_q[0] ? D_READ : D_WRITE; // RULE4
            end else if (rx_q == `TWSSP_GCALL) begin
              ack_q    <= 1'b1; // RULE21
              sda_oe_q <= 1'b1;
              gc_q     <= 1'b1;
              st_q     <= D_WRITE;
            end else begin
              hs_mode_q <= hs_mode_q || rx_q[7:3] == `TWSSP_HS_PREFIX; // RULE22
              st_q      <= D_IGNORE; // RULE24
            end
          end else if (byte_in) begin
            ack_q    <= 1'b1; // RULE18
            sda_oe_q <= 1'b1;
            first_q  <= 1'b0;
            if (gc_q) begin
              if (rx_q == `TWSSP_GC_RESET) begin
                sw_reset_q <= 1'b1; // RULE21
                ptr_q      <= `TWSSP_PTR_RESET;
              end
            end else if (first_q) begin
              ptr_q <= rx_q; // RULE10
            end else begin
              wr_data_q <= rx_q;
              wr_stb_q  <= 1'b1;
            end
          end else if (scl_fall && ack_q) begin
            ack_q    <= 1'b0;
            sda_oe_q <= 1'b0;
            bit_q    <= 4'h0;
          end
        end
        D_READ: begin
          if (ack_q && scl_rise && s_sda) begin
            ack_q <= 1'b0; // RULE14
            st_q  <= D_IGNORE;
          end else if (ack_q && scl_fall) begin
            tx_q     <= rd_byte; // RULE11
            sda_oe_q <= !rd_byte[7];
            lsb_q    <= !lsb_q; // RULE15
            bit_q    <= 4'h1;
            ack_q    <= 1'b0;
          end else if (scl_fall && bit_q == 4'h8) begin
            sda_oe_q <= 1'b0;
            ack_q    <= 1'b1;
          end else if (scl_fall) begin
            sda_oe_q <= !tx_q[6]; // RULE2
            tx_q     <= {tx_q[6:0], 1'b0};
            bit_q    <= bit_q + 4'h1;
          end
        end
        D_IDLE, D_IGNORE: begin
          sda_oe_q <= 1'b0;
        end
        default: begin
          st_q     <= D_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: hdl/twssp_params.svh
/*
  Constants of the two-wire sensor slave port: addresses, codes and times.
  Assumes inclusion by bare name from the package and the two design ends.
*/
// Contract
// RULE1: Device only answers; never drives clock.
// RULE2: Bytes travel most significant bit first.
// RULE3: Slave works up to fast and high-speed rates.
// RULE4: First byte: seven address bits, then direction.
// RULE5: Pin variant: two tri-level pins pick address.
// RULE6: Dual variant: probed polarities set address bits.
// RULE7: Reset probes pin one, then pin two.
// RULE8: Shorted or open pins give bit zero.
// RULE9: Triple variant uses fixed preset address.
// RULE10: First written byte loads the pointer.
// RULE11: Reads return pointed register; pointer persists.
// RULE12: Pointer-only write, repeated start, then read.
// RULE13: Two-byte register sends high byte first.
// RULE14: Single-byte read ends with master not-acknowledge.
// RULE15: Two-byte read: acknowledge first, not-acknowledge second.
// RULE16: Data falling while clock high is start.
// RULE17: Data rising while clock high is stop.
// RULE18: Master sets byte count; receiver acknowledges each.
// RULE19: Acknowledge holds data low through ninth clock.
// RULE20: Both lines high outside transfer means idle.
// RULE21: General call acknowledged; 06h performs software reset.
// RULE22: High-speed code unacknowledged; high-speed until stop.
// RULE23: Line low too long resets the interface.
// RULE24: Unmatched address: stay released, ignore transfer.
`ifndef TWSSP_PARAMS_SVH
`define TWSSP_PARAMS_SVH

`define TWSSP_VAR_PIN      0
`define TWSSP_VAR_DUAL     1
`define TWSSP_VAR_TRIPLE   2

`define TWSSP_ADDR_F0      7'h1C
`define TWSSP_ADDR_F1      7'h1D
`define TWSSP_ADDR_0F      7'h1E
`define TWSSP_ADDR_1F      7'h1F
`define TWSSP_ADDR_FF      7'h2A
`define TWSSP_ADDR_BASE    5'h13
`define TWSSP_ADDR_TRI_A   7'h4C
`define TWSSP_ADDR_TRI_B   7'h4D
`define TWSSP_GCALL        8'h00
`define TWSSP_GC_RESET     8'h06
`define TWSSP_HS_PREFIX    5'h01
`define TWSSP_PTR_RESET    8'h00

`define TWSSP_CORE_HZ      125000000
`define TWSSP_SCL_HZ       400000
`define TWSSP_QTR_CYC      ((`TWSSP_CORE_HZ + 4 * `TWSSP_SCL_HZ - 1) / (4 * `TWSSP_SCL_HZ))
`define TWSSP_LINK_NS      48
`define TWSSP_TIMEOUT_US   30000
`define TWSSP_TIMEOUT_CYC  ((`TWSSP_TIMEOUT_US * 1000) / `TWSSP_LINK_NS)
`define TWSSP_PROBE_NS     500
`define TWSSP_PROBE_CYC    ((`TWSSP_PROBE_NS + `TWSSP_LINK_NS - 1) / `TWSSP_LINK_NS)

`endif

// File: hdl/twssp_pkg.sv
/*
  Types shared by both ends of the two-wire sensor slave port.
  Assumes the constants header is on the include path.
*/
`include "twssp_params.svh"
package twssp_pkg;
  // Device protocol states, one-hot.
  typedef enum logic [4:0] {
    D_IDLE   = 5'h01,
    D_ADDR   = 5'h02,
    D_WRITE  = 5'h04,
    D_READ   = 5'h08,
    D_IGNORE = 5'h10
  } twssp_dstate_t;
  // Host sequencer states, one-hot.
  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_BYTE  = 4'h4,
    H_STOP  = 4'h8
  } twssp_hstate_t;
endpackage

// File: hdl/twssp_if.sv
/*
  Two-wire bus between host end and device end, open-drain wired-AND.
  Assumes released lines are pulled high; enables pull the line low.
*/
`timescale 1ns/1ps
`default_nettype none
interface twssp_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_scl_o;
  logic d_scl_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;
  // Wired-AND resolution of both drivers with pull-ups.
  assign scl = !(m_scl_oe && !m_scl_o) && !(d_scl_oe && !d_scl_o);
  assign sda = !(m_sda_oe && !m_sda_o) && !(d_sda_oe && !d_sda_o);
  modport host (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe,
                input scl, sda);
  modport device (output d_scl_o, d_scl_oe, d_sda_o, d_sda_oe,
                  input scl, sda);
endinterface
`default_nettype wire

// File: hdl/twssp_host.sv
/*
  Host end: bus master that makes the serial clock from core_clk.
  Assumes one command at a time by valid/ready on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "twssp_params.svh"
module twssp_host
  import twssp_pkg::*;
#(
  parameter int QTR_CYC = `TWSSP_QTR_CYC
) (
  input  wire logic        core_clk,    // Core clock.
  input  wire logic        rst,         // Synchronous reset, high.
  twssp_if.host            bus,         // Two-wire bus.
  input  wire logic        cmd_valid,   // Command offered.
  output logic             cmd_ready_q, // Host idle, command taken.
  input  wire logic [6:0]  cmd_addr,    // Slave address.
  input  wire logic        cmd_read,    // Read transfer.
  input  wire logic        cmd_ptr_en,  // Read: write pointer first.
  input  wire logic [7:0]  cmd_ptr,     // Pointer byte.
  input  wire logic [1:0]  cmd_wlen,    // Write: data bytes, 0 to 2.
  input  wire logic [15:0] cmd_wdata,   // Write data, high byte first.
  input  wire logic        cmd_two,     // Read: two bytes.
  output logic             rsp_valid_q, // Transfer done, pulse.
  output logic             rsp_nack_q,  // A sent byte was refused.
  output logic      [15:0] rsp_data_q   // Read data, first of two bytes high, a single byte low.
);
  localparam int QW = $clog2(QTR_CYC + 1);

  twssp_hstate_t st_q;
  logic [QW-1:0] qcnt_q;
  logic [1:0]    phase_q;
  logic [1:0]    sda_sync_q;
  logic          scl_oe_q;
  logic          sda_oe_q;
  logic [3:0]    bitn_q;
  logic [7:0]    tx_q;
  logic [7:0]    rx_q;
  logic [23:0]   wbuf_q;
  logic [1:0]    wleft_q;
  logic [1:0]    rleft_q;
  logic          rd_pend_q;
  logic          raddr_q;
  logic          rx_mode_q;
  logic [6:0]    addr_q;
  logic          tick;
  logic          wr_phase;

  assign bus.m_scl_o  = 1'b0;
  assign bus.m_scl_oe = scl_oe_q;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = sda_oe_q;
  assign tick     = (qcnt_q == QW'(QTR_CYC - 1));
  assign wr_phase = !cmd_read || cmd_ptr_en;

  // Quarter-period timer and data line synchroniser.
  always_ff @(posedge core_clk) begin
    sda_sync_q <= {sda_sync_q[0], bus.sda};
    if (rst || tick) begin
      qcnt_q <= '0;
    end else begin
      qcnt_q <= qcnt_q + 1'b1;
    end
  end

  // Bit sequencer: start, bytes with acknowledge, stop.
  always_ff @(posedge core_clk) begin
    rsp_valid_q <= 1'b0;
    if (rst) begin
      st_q        <= H_IDLE;
      phase_q     <= 2'h0;
      scl_oe_q    <= 1'b0;
      sda_oe_q    <= 1'b0;
      cmd_ready_q <= 1'b1;
      rsp_nack_q  <= 1'b0;
      rsp_data_q  <= 16'h0000;
      bitn_q      <= 4'h0;
      tx_q        <= 8'h00;
      rx_q        <= 8'h00;
      wbuf_q      <= 24'h000000;
      wleft_q     <= 2'h0;
      rleft_q     <= 2'h0;
      rd_pend_q   <= 1'b0;
      raddr_q     <= 1'b0;
      rx_mode_q   <= 1'b0;
      addr_q      <= 7'h00;
    end else if (st_q == H_IDLE) begin
      if (cmd_valid) begin
        st_q        <= H_START; // RULE16
        phase_q     <= 2'h0;
        cmd_ready_q <= 1'b0;
        rsp_nack_q  <= 1'b0;
        rsp_data_q  <= 16'h0000;
        addr_q      <= cmd_addr;
        tx_q        <= {cmd_addr, !wr_phase}; // RULE4
        wbuf_q      <= {cmd_ptr, cmd_wdata}; // RULE10
        wleft_q     <= !wr_phase ? 2'h0 :
                       (cmd_read ? 2'h1 : 2'h1 + cmd_wlen);
        rd_pend_q   <= cmd_read && cmd_ptr_en; // RULE12
        raddr_q     <= !wr_phase;
        rx_mode_q   <= 1'b0;
        rleft_q     <= cmd_two ? 2'h2 : 2'h1;
      end
    end else if (tick) begin
      phase_q <= phase_q + 2'h1;
      case (st_q)
        H_START: begin
          case (phase_q)
            2'h0: sda_oe_q <= 1'b0;
            2'h1: scl_oe_q <= 1'b0;
            2'h2: sda_oe_q <= 1'b1; // RULE16
            default: begin
              scl_oe_q <= 1'b1;
              bitn_q   <= 4'h0;
              st_q     <= H_BYTE;
            end
          endcase
        end
        H_BYTE: begin
          case (phase_q)
            2'h0: begin
              if (bitn_q != 4'h8) begin
                sda_oe_q <= !rx_mode_q && !tx_q[7]; // RULE2
              end else begin
                sda_oe_q <= rx_mode_q && rleft_q != 2'h1; // RULE15
              end
            end
            2'h1: scl_oe_q <= 1'b0;
            2'h2: begin
              if (bitn_q != 4'h8) begin
                rx_q <= {rx_q[6:0], sda_sync_q[1]};
                tx_q <= {tx_q[6:0], 1'b0};
              end else if (!rx_mode_q && sda_sync_q[1]) begin
                rsp_nack_q <= 1'b1; // RULE19
              end
            end
            default: begin
              scl_oe_q <= 1'b1;
              bitn_q   <= bitn_q + 4'h1;
              if (bitn_q == 4'h8) begin
                bitn_q <= 4'h0;
                if (!rx_mode_q && rsp_nack_q) begin
                  st_q <= H_STOP;
                end else if (rx_mode_q) begin
                  rsp_data_q <= {rsp_data_q[7:0], rx_q}; // RULE13
                  rleft_q    <= rleft_q - 2'h1;
                  if (rleft_q == 2'h1) begin
                    st_q <= H_STOP; // RULE14
                  end
                end else if (raddr_q) begin
                  raddr_q   <= 1'b0;
                  rx_mode_q <= 1'b1;
                end else if (wleft_q != 2'h0) begin
                  tx_q    <= wbuf_q[23:16]; // RULE18
                  wbuf_q  <= {wbuf_q[15:0], 8'h00};
                  wleft_q <= wleft_q - 2'h1;
                end else if (rd_pend_q) begin
                  st_q      <= H_START; // RULE12
                  rd_pend_q <= 1'b0;
                  raddr_q   <= 1'b1;
                  tx_q      <= {addr_q, 1'b1};
                end else begin
                  st_q <= H_STOP;
                end
              end
            end
          endcase
        end
        H_STOP: begin
          case (phase_q)
            2'h0: sda_oe_q <= 1'b1;
            2'h1: scl_oe_q <= 1'b0;
            2'h2: sda_oe_q <= 1'b0; // RULE17
            default: begin
              st_q        <= H_IDLE; // RULE20
              cmd_ready_q <= 1'b1;
              rsp_valid_q <= 1'b1;
            end
          endcase
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: verif/twssp_props.sv
/*
  Checker of the two-wire bus joining the host end and the device end.
  Assumes the bench hands over bus lines, enables, both clocks and resets.
*/
`timescale 1ns/1ps
`default_nettype none
module twssp_props (
  input wire logic core_clk, // Host clock.
  input wire logic link_clk, // Link clock.
  input wire logic rst,      // Host reset.
  input wire logic link_rst, // Device reset.
  input wire logic scl,      // Clock line.
  input wire logic sda,      // Data line.
  input wire logic m_scl_oe, // Host pulls clock.
  input wire logic d_scl_oe, // Device pulls clock.
  input wire logic d_sda_oe  // Device pulls data.
);
  localparam int MIN_HI = 75; // 600 ns of clock high at 8 ns.
  int hi_cnt;
  // Counts host cycles for which the clock line has stayed high.
  always_ff @(posedge core_clk) begin
    if (rst || !scl) begin
      hi_cnt <= 0;
    end else begin
      hi_cnt <= hi_cnt + 1;
    end
  end
  int low_cnt;
  // Counts link cycles for which the device has held the data line low.
  always_ff @(posedge link_clk) begin
    if (link_rst || !d_sda_oe) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  chk_dev_release: assert property (@(posedge link_clk)
    disable iff (link_rst) low_cnt < 2000) else $error("device held data");
  // The device never touches the clock and moves data in the low phase.
  chk_dev_no_clock: assert property (@(posedge link_clk)
    disable iff (link_rst) !d_scl_oe) else $error("device drove clock");
  chk_dev_low_phase: assert property (@(posedge link_clk)
    disable iff (link_rst) $changed(d_sda_oe) |-> !scl && !$past(scl))
    else $error("device data moved near clock high");
  chk_ack_held_high: assert property (@(posedge link_clk)
    disable iff (link_rst) $rose(scl) && d_sda_oe |-> d_sda_oe[*8])
    else $error("device low level not held through clock high");
  // Only the host ever holds the clock low, and it keeps the high phase.
  chk_clock_owner: assert property (@(posedge core_clk)
    disable iff (rst) !scl == m_scl_oe) else $error("clock owner wrong");
  chk_scl_high_time: assert property (@(posedge core_clk)
    disable iff (rst) $fell(scl) |-> hi_cnt >= MIN_HI)
    else $error("clock high phase too short");
  // Framing: idle after reset, a start is clocked, a stop leaves idle.
  chk_idle_after_reset: assert property (@(posedge core_clk)
    disable iff (rst) $fell(rst) |-> scl && sda)
    else $error("bus not idle after reset");
  chk_start_clocks: assert property (@(posedge core_clk)
    disable iff (rst) $fell(sda) && scl |-> ##[1:100] !scl)
    else $error("start not followed by clock");
  chk_stop_idle: assert property (@(posedge core_clk)
    disable iff (rst) $rose(sda) && scl |-> (scl && sda)[*8])
    else $error("stop not followed by idle bus");
  // Main scenarios reached.
  cov_ack: cover property (@(posedge link_clk) $rose(d_sda_oe));
  cov_start: cover property (@(posedge core_clk) $fell(sda) && scl);
  cov_stop: cover property (@(posedge core_clk) $rose(sda) && scl);
endmodule
`default_nettype wire

// File: verif/twssp_test.sv
/*
  Self-checking bench: host end and device end joined by the bus.
  Assumes the package, interface and both design ends compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module twssp_test
  import twssp_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst = 1'b1;
  logic        link_rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        cmd_read = 1'b0;
  logic        cmd_ptr_en = 1'b0;
  logic        cmd_two = 1'b0;
  logic [6:0]  cmd_addr = 7'h00;
  logic [7:0]  cmd_ptr = 8'h00;
  logic [1:0]  cmd_wlen = 2'h0;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [1:0]  sel_hi = 2'h0;
  logic [1:0]  sel_lo = 2'h0;
  logic [15:0] rd_data = 16'h0000;
  logic        cmd_ready_q, rsp_valid_q, rsp_nack_q;
  logic        wr_stb_q, sw_reset_q, hs_mode_q;
  logic [15:0] rsp_data_q;
  logic [15:0] wd_log = 16'h0000;
  logic [7:0]  ptr_q, wr_data_q;
  logic [6:0]  own_addr_q;
  logic [3:0]  probe_q;
  int          errors = 0, samples_checked = 0, test_no = 0;
  int          stb_cnt = 0, sw_cnt = 0, hs_cnt = 0, stb0, sw0, hs0;
  logic [3:0]  straps [9] = '{4'h8, 4'h9, 4'h2, 4'h6, 4'hA, 4'h1, 4'h4,
                              4'h5, 4'h0};
  logic [6:0]  addrs [9] = '{7'h1C, 7'h1D, 7'h1E, 7'h1F, 7'h2A, 7'h4D,
                             7'h4E, 7'h4F, 7'h4C};
  twssp_if bus ();
  twssp_host #(.QTR_CYC(40)) u_twssp_host (.core_clk(core_clk), .rst(rst),
    .bus(bus), .cmd_valid(cmd_valid), .cmd_ready_q(cmd_ready_q),
    .cmd_addr(cmd_addr), .cmd_read(cmd_read), .cmd_ptr_en(cmd_ptr_en),
    .cmd_ptr(cmd_ptr), .cmd_wlen(cmd_wlen), .cmd_wdata(cmd_wdata),
    .cmd_two(cmd_two), .rsp_valid_q(rsp_valid_q), .rsp_nack_q(rsp_nack_q),
    .rsp_data_q(rsp_data_q));
  twssp_dev #(.TIMEOUT_CYC(2000)) u_twssp_dev (.link_clk(link_clk),
    .rst(link_rst), .bus(bus), .addr_select_hi_pin(sel_hi),
    .addr_select_lo_pin(sel_lo), .sense_rise(4'h0), .probe_drive_q(probe_q),
    .rd_data(rd_data), .ptr_q(ptr_q), .wr_data_q(wr_data_q),
    .wr_stb_q(wr_stb_q), .sw_reset_q(sw_reset_q), .hs_mode_q(hs_mode_q),
    .own_addr_q(own_addr_q));
  twssp_props u_twssp_props (.core_clk(core_clk), .link_clk(link_clk),
    .rst(rst), .link_rst(link_rst), .scl(bus.scl), .sda(bus.sda),
    .m_scl_oe(bus.m_scl_oe), .d_scl_oe(bus.d_scl_oe),
    .d_sda_oe(bus.d_sda_oe));
  // Clocks of unrelated phase; link reset spans four link edges.
  always #4 core_clk = ~core_clk;
  initial begin
    #5;
    forever #24 link_clk = ~link_clk;
  end
  initial begin
    repeat (4) @(posedge link_clk);
    link_rst <= 1'b0;
  end
  // Register contents follow the pointer; device events are logged.
  always @(posedge link_clk) begin
    rd_data <= {~ptr_q, ptr_q ^ 8'h3C};
    if (wr_stb_q === 1'b1) stb_cnt <= stb_cnt + 1;
    if (wr_stb_q === 1'b1) wd_log <= {wd_log[7:0], wr_data_q};
    if (sw_reset_q === 1'b1) sw_cnt <= sw_cnt + 1;
    if (hs_mode_q === 1'b1) hs_cnt <= hs_cnt + 1;
  end
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One whole transfer: offer, hold until taken, wait for the answer.
  task automatic xfer(input logic [6:0] a, input logic rd, input logic pe,
                      input logic [7:0] p, input logic [1:0] wl,
                      input logic [15:0] wd, input logic two);
    int n;
    n = 0;
    stb0 = stb_cnt;
    sw0 = sw_cnt;
    hs0 = hs_cnt;
    @(posedge core_clk);
    {cmd_addr, cmd_read, cmd_ptr_en, cmd_ptr} <= {a, rd, pe, p};
    {cmd_wlen, cmd_wdata, cmd_two, cmd_valid} <= {wl, wd, two, 1'b1};
    do @(posedge core_clk); while (cmd_ready_q !== 1'b1);
    cmd_valid <= 1'b0;
    while (rsp_valid_q !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    chk("rsp_valid_q", 16'h0001, {15'h0, n < 20000});
    repeat (4) @(posedge link_clk);
  endtask
  task automatic ends(input logic nk, input logic [7:0] p);
    chk("rsp_nack_q", {15'h0, nk}, {15'h0, rsp_nack_q});
    chk("ptr_q", {8'h00, p}, {8'h00, ptr_q});
    test_no++;
    $display("Test %0d done", test_no);
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Cuts a hang short well beyond the expected length of the run.
  initial begin
    repeat (95000) @(posedge core_clk);
    errors++;
    $display("ERROR watchdog expected done seen hang");
    complete_run();
  end
  // Strap table, then transfers to 4C, to a wrong address, with the high-speed code and to the general call.
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      {sel_hi, sel_lo} <= straps[i];
      repeat (60) @(posedge core_clk);
      chk("own_addr_q", {9'h0, addrs[i]}, {9'h0, own_addr_q});
    end
    chk("probe_drive_q", 16'h0000, {12'h000, probe_q});
    $display("Test straps done");
    xfer(7'h4C, 1'b0, 1'b0, 8'h5A, 2'h0, 16'h0000, 1'b0);
    ends(1'b0, 8'h5A);
    xfer(7'h4C, 1'b0, 1'b0, 8'h21, 2'h2, 16'hC396, 1'b0);
    chk("wr_stb_q count", 16'h0002, 16'(stb_cnt - stb0));
    chk("wr_data_q", 16'hC396, wd_log);
    ends(1'b0, 8'h21);
    xfer(7'h4C, 1'b1, 1'b1, 8'h81, 2'h0, 16'h0000, 1'b1);
    chk("rsp_data_q", 16'h7EBD, rsp_data_q);
    ends(1'b0, 8'h81);
    xfer(7'h4C, 1'b1, 1'b0, 8'h00, 2'h0, 16'h0000, 1'b0);
    chk("rsp_data_q", 16'h007E, {8'h00, rsp_data_q[7:0]});
    ends(1'b0, 8'h81);
    xfer(7'h4D, 1'b0, 1'b0, 8'h33, 2'h0, 16'h0000, 1'b0);
    ends(1'b1, 8'h81);
    xfer(7'h04, 1'b0, 1'b0, 8'h33, 2'h0, 16'h0000, 1'b0);
    chk("hs_mode_q seen", 16'h0001, {15'h0, hs_cnt > hs0});
    chk("hs_mode_q", 16'h0000, {15'h0, hs_mode_q});
    ends(1'b1, 8'h81);
    xfer(7'h00, 1'b0, 1'b0, 8'h07, 2'h0, 16'h0000, 1'b0);
    chk("sw_reset_q count", 16'h0000, 16'(sw_cnt - sw0));
    ends(1'b0, 8'h81);
    xfer(7'h00, 1'b0, 1'b0, 8'h06, 2'h0, 16'h0000, 1'b0);
    chk("sw_reset_q count", 16'h0001, 16'(sw_cnt - sw0));
    ends(1'b0, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
